// ===== core/flt_defines.svh
`ifndef FLT_DEFINES_SVH
`define FLT_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define FLT_CLK_NS 100
`define FLT_STEP_MS 32
`define FLT_STEP_CYCLES ((`FLT_STEP_MS * 1000000) / `FLT_CLK_NS)
`define FLT_PRE_W 19
`define FLT_DUR_W 5

// ****************************************
// Register offsets
// ****************************************
`define FLT_ADDR_CFG1 8'h00
`define FLT_ADDR_ENABLE 8'h01
`define FLT_ADDR_DUR 8'h02
`define FLT_ADDR_TORCH_A 8'h03
`define FLT_ADDR_TORCH_B 8'h04
`define FLT_ADDR_FLASH_A 8'h05
`define FLT_ADDR_FLASH_B 8'h06
`define FLT_ADDR_STATUS 8'h07
`define FLT_ADDR_CLEAR 8'h08
`define FLT_ADDR_IRQ_EN 8'h09

// ****************************************
// Reset values
// ****************************************
`define FLT_RST_CFG1 8'h20
`define FLT_RST_ENABLE 8'h18
`define FLT_RST_DUR 8'h0f
`define FLT_RST_LEVEL 8'h00
`define FLT_RST_ZERO 8'h00

// ****************************************
// Fields
// ****************************************
`define FLT_CFG1_HWTORCH 7
`define FLT_CFG1_POL 5
`define FLT_EN_A 3
`define FLT_EN_B 4
`define FLT_MODE_HI 1
`define FLT_MODE_LO 0
`define FLT_MODE_OFF 2'h0
`define FLT_MODE_TORCH 2'h2
`define FLT_MODE_FLASH 2'h3
`define FLT_DUR_HI 4
`define FLT_DUR_LO 0

`define FLT_FLAG_TIMEOUT 0
`define FLT_FLAG_TSD 1
`define FLT_FLAG_LED_FAIL 2
`define FLT_FLAG_OVERTEMP 3
`define FLT_FLAG_SYNC 4
`define FLT_FLAG_RSVD 5
`define FLT_FLAG_FLASH_MON 6
`define FLT_FLAG_UVLO 7

`define FLT_SYNC_W 4
`define FLT_SYNC_HARDWARE_ENABLE_PIN 0
`define FLT_SYNC_TRIG 1
`define FLT_SYNC_MFP 2
`define FLT_SYNC_TX2 3

`endif

// ===== core/flt_pkg.sv
package flt_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flt_bus_req_t;

  typedef struct packed {
    logic thermal_shutdown;
    logic led_fail;
    logic led_overtemp;
    logic flash_monitor_trip;
    logic input_undervoltage;
  } flt_fault_t;

  typedef enum logic [1:0] {
    FLT_IDLE,
    FLT_TORCH,
    FLT_FLASH,
    FLT_DONE
  } flt_state_t;

endpackage

// ===== core/flt_sync.sv
`timescale 1ns/10ps
`include "flt_defines.svh"

module flt_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`FLT_SYNC_W-1:0] din,
  output logic [`FLT_SYNC_W-1:0] dout
);
  import flt_pkg::*;

  logic [`FLT_SYNC_W-1:0] meta_q;

  // ****************************************
  // Two-stage synchronisers
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `FLT_SYNC_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else if (ce) begin
          meta_q[i] <= din[i];
          dout[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2))
      |-> dout == $past(din, 2))
    else $error("Synchronised input is not the pin value two cycles late");

endmodule

// ===== core/flt_timer.sv
`timescale 1ns/10ps
`include "flt_defines.svh"

module flt_timer #(
  parameter int STEP_CYCLES = `FLT_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [`FLT_DUR_W-1:0] dur,
  output logic expired
);
  import flt_pkg::*;

  logic [`FLT_PRE_W-1:0] pre_q;
  logic [`FLT_DUR_W-1:0] step_q;
  logic tick;

  // ****************************************
  // 32 ms step prescaler
  // ****************************************
  assign tick = run && (pre_q == `FLT_PRE_W'(STEP_CYCLES - 1));
  assign expired = tick && (step_q == dur);

  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      pre_q <= '0;
    end else if (ce) begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      step_q <= '0;
    end else if (ce && tick) begin
      step_q <= step_q + 1'b1;
    end
  end

  AST_TIMEOUT_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && run && !tick) |=> pre_q == $past(pre_q) + 1'b1)
    else $error("Step prescaler did not count while the flash ran");

  AST_TIMEOUT_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && tick && !expired) |=> step_q == $past(step_q) + 1'b1)
    else $error("Step counter did not advance on a step boundary");

endmodule

// ===== core/flt_ctrl.sv
// Operation
// - Config bit 7 low selects sync input
// - Sync active during flash forces torch level
// - Sync release restores previous flash level
// - Timeout turns both sources off
// - Config bit 5 sets sync polarity
// - Seven readable sticky status flags
// - Enable pin low forces prompt shutdown
// - Trigger pin starts flash without software
// - Config bit 7 high gives pin torch
// - Timeout field: 32 steps of 32 ms
`timescale 1ns/10ps
`include "flt_defines.svh"

module flt_ctrl #(
  parameter int STEP_CYCLES = `FLT_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input flt_pkg::flt_bus_req_t bus,
  output logic [7:0] rd_data,
  input wire logic hardware_enable_pin,
  input wire logic flash_trigger_pin,
  input wire logic multi_function_sync_pin,
  input wire logic pa_sync_input2,
  input flt_pkg::flt_fault_t faults,
  output logic [7:0] current_source_a,
  output logic [7:0] current_source_b,
  output logic irq
);
  import flt_pkg::*;

  logic [`FLT_SYNC_W-1:0] pins_s;
  logic hardware_enable_pin_s;
  logic trig_s;
  logic mfp_s;
  logic tx2_s;
  logic off;
  logic [7:0] cfg1_q;
  logic [7:0] en_q;
  logic [7:0] dur_q;
  logic [7:0] torch_a_q;
  logic [7:0] torch_b_q;
  logic [7:0] flash_a_q;
  logic [7:0] flash_b_q;
  logic [7:0] flag_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] irq_en_q;
  flt_state_t state_q;
  flt_state_t state_d;
  logic tx1_act;
  logic sync_act;
  logic sync_act_q;
  logic flash_req;
  logic torch_req;
  logic expired;
  logic [7:0] out_a_d;
  logic [7:0] out_b_d;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // ****************************************
  // Pin synchronisers and timer
  // ****************************************
  flt_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din({pa_sync_input2, multi_function_sync_pin, flash_trigger_pin, hardware_enable_pin}),
    .dout(pins_s)
  );

  assign hardware_enable_pin_s = pins_s[`FLT_SYNC_HARDWARE_ENABLE_PIN];
  assign trig_s = pins_s[`FLT_SYNC_TRIG];
  assign mfp_s = pins_s[`FLT_SYNC_MFP];
  assign tx2_s = pins_s[`FLT_SYNC_TX2];

  // Shutdown whenever the enable pin is low
  assign off = rst || !hardware_enable_pin_s;

  flt_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(off),
    .ce(ce),
    .run(state_q == FLT_FLASH),
    .dur(dur_q[`FLT_DUR_HI:`FLT_DUR_LO]),
    .expired(expired)
  );

  // ****************************************
  // Requests
  // ****************************************
  assign tx1_act = !cfg1_q[`FLT_CFG1_HWTORCH]
    && (mfp_s == cfg1_q[`FLT_CFG1_POL]);
  assign sync_act = tx1_act || tx2_s;
  assign flash_req = trig_s
    || (en_q[`FLT_MODE_HI:`FLT_MODE_LO] == `FLT_MODE_FLASH);
  assign torch_req = (en_q[`FLT_MODE_HI:`FLT_MODE_LO] == `FLT_MODE_TORCH)
    || (cfg1_q[`FLT_CFG1_HWTORCH] && mfp_s);

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      FLT_IDLE: begin
        if (flash_req) begin
          state_d = FLT_FLASH;
        end else if (torch_req) begin
          state_d = FLT_TORCH;
        end
      end
      FLT_TORCH: begin
        if (flash_req) begin
          state_d = FLT_FLASH;
        end else if (!torch_req) begin
          state_d = FLT_IDLE;
        end
      end
      FLT_FLASH: begin
        if (expired) begin
          state_d = FLT_DONE;
        end
      end
      FLT_DONE: begin
        if (!trig_s) begin
          state_d = FLT_IDLE;
        end
      end
      default: begin
        state_d = FLT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      state_q <= FLT_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Current source levels
  // ****************************************
  always_comb begin
    out_a_d = `FLT_RST_LEVEL;
    out_b_d = `FLT_RST_LEVEL;
    case (state_q)
      FLT_FLASH: begin
        if (sync_act) begin
          out_a_d = torch_a_q;
          out_b_d = torch_b_q;
        end else begin
          out_a_d = flash_a_q;
          out_b_d = flash_b_q;
        end
      end
      FLT_TORCH: begin
        out_a_d = torch_a_q;
        out_b_d = torch_b_q;
      end
      FLT_DONE: begin
        out_a_d = `FLT_RST_LEVEL;
        out_b_d = `FLT_RST_LEVEL;
      end
      default: begin
        out_a_d = `FLT_RST_LEVEL;
        out_b_d = `FLT_RST_LEVEL;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      current_source_a <= `FLT_RST_LEVEL;
      current_source_b <= `FLT_RST_LEVEL;
    end else if (ce) begin
      current_source_a <= en_q[`FLT_EN_A] ? out_a_d : `FLT_RST_LEVEL;
      current_source_b <= en_q[`FLT_EN_B] ? out_b_d : `FLT_RST_LEVEL;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (off) begin
      cfg1_q <= `FLT_RST_CFG1;
    end else if (ce) begin
      if (bus.wr && hit(bus.addr, `FLT_ADDR_CFG1)) begin
        cfg1_q <= bus.wdata;
      end else if (expired && cfg1_q[`FLT_CFG1_HWTORCH]) begin
        cfg1_q[`FLT_CFG1_HWTORCH] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      en_q <= `FLT_RST_ENABLE;
    end else if (ce) begin
      if (bus.wr && hit(bus.addr, `FLT_ADDR_ENABLE)) begin
        en_q <= bus.wdata;
      end else if (expired) begin
        en_q[`FLT_MODE_HI:`FLT_MODE_LO] <= `FLT_MODE_OFF;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      dur_q <= `FLT_RST_DUR;
      torch_a_q <= `FLT_RST_LEVEL;
      torch_b_q <= `FLT_RST_LEVEL;
      flash_a_q <= `FLT_RST_LEVEL;
      flash_b_q <= `FLT_RST_LEVEL;
      irq_en_q <= `FLT_RST_ZERO;
    end else if (ce && bus.wr) begin
      if (hit(bus.addr, `FLT_ADDR_DUR)) begin
        dur_q <= bus.wdata;
      end
      if (hit(bus.addr, `FLT_ADDR_TORCH_A)) begin
        torch_a_q <= bus.wdata;
      end
      if (hit(bus.addr, `FLT_ADDR_TORCH_B)) begin
        torch_b_q <= bus.wdata;
      end
      if (hit(bus.addr, `FLT_ADDR_FLASH_A)) begin
        flash_a_q <= bus.wdata;
      end
      if (hit(bus.addr, `FLT_ADDR_FLASH_B)) begin
        flash_b_q <= bus.wdata;
      end
      if (hit(bus.addr, `FLT_ADDR_IRQ_EN)) begin
        irq_en_q <= bus.wdata;
      end
    end
  end

  // ****************************************
  // Sticky flags and interrupt
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (off) begin
      sync_act_q <= 1'b0;
    end else if (ce) begin
      sync_act_q <= sync_act;
    end
  end

  always_comb begin
    flag_set = `FLT_RST_ZERO;
    flag_set[`FLT_FLAG_TIMEOUT] = expired;
    flag_set[`FLT_FLAG_TSD] = faults.thermal_shutdown;
    flag_set[`FLT_FLAG_LED_FAIL] = faults.led_fail;
    flag_set[`FLT_FLAG_OVERTEMP] = faults.led_overtemp;
    flag_set[`FLT_FLAG_SYNC] = (state_q == FLT_FLASH) && sync_act && !sync_act_q;
    flag_set[`FLT_FLAG_FLASH_MON] = faults.flash_monitor_trip;
    flag_set[`FLT_FLAG_UVLO] = faults.input_undervoltage;
  end

  assign flag_clr = (bus.wr && hit(bus.addr, `FLT_ADDR_CLEAR)) ? bus.wdata : `FLT_RST_ZERO;

  always_ff @(posedge clk_sys) begin
    if (off) begin
      flag_q <= `FLT_RST_ZERO;
    end else if (ce) begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  assign irq = |(flag_q & irq_en_q);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= `FLT_RST_ZERO;
    end else if (ce) begin
      rd_data <= `FLT_RST_ZERO;
      if (bus.rd) begin
        case (bus.addr)
          `FLT_ADDR_CFG1: rd_data <= cfg1_q;
          `FLT_ADDR_ENABLE: rd_data <= en_q;
          `FLT_ADDR_DUR: rd_data <= dur_q;
          `FLT_ADDR_TORCH_A: rd_data <= torch_a_q;
          `FLT_ADDR_TORCH_B: rd_data <= torch_b_q;
          `FLT_ADDR_FLASH_A: rd_data <= flash_a_q;
          `FLT_ADDR_FLASH_B: rd_data <= flash_b_q;
          `FLT_ADDR_STATUS: rd_data <= flag_q;
          `FLT_ADDR_IRQ_EN: rd_data <= irq_en_q;
          default: rd_data <= `FLT_RST_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_SYNC_MODE: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_FLASH && cfg1_q[`FLT_CFG1_HWTORCH] && !tx2_s
      && en_q[`FLT_EN_A]) |=> current_source_a == $past(flash_a_q))
    else $error("Sync input active while pin is in torch mode");

  AST_TX_TORCH: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_FLASH && sync_act && !expired && en_q[`FLT_EN_A])
      |=> current_source_a == $past(torch_a_q))
    else $error("Sync during flash did not give torch level");

  AST_TX_RESTORE: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_FLASH && !sync_act && !expired && en_q[`FLT_EN_B])
      |=> current_source_b == $past(flash_b_q))
    else $error("Flash level not restored after sync release");

  AST_TIMEOUT_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && expired) |=> (state_q == FLT_DONE) ##1 (!$past(ce)
      || ((current_source_a == 8'h00) && (current_source_b == 8'h00))))
    else $error("Current sources still on after timeout");

  AST_POLARITY_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_FLASH && !expired && en_q[`FLT_EN_A]
      && !cfg1_q[`FLT_CFG1_HWTORCH] && !cfg1_q[`FLT_CFG1_POL] && !mfp_s)
      |=> current_source_a == $past(torch_a_q))
    else $error("Low sync level with low polarity did not force torch");

  AST_FLAG_TIMEOUT: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && expired) |=> flag_q[`FLT_FLAG_TIMEOUT] ##1 (!$past(hardware_enable_pin_s)
      || $past(flag_clr[`FLT_FLAG_TIMEOUT]) || flag_q[`FLT_FLAG_TIMEOUT]))
    else $error("Timeout flag not set or not held");

  AST_HARDWARE_ENABLE_PIN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    !hardware_enable_pin_s |=> (current_source_a == 8'h00) && (current_source_b == 8'h00)
      && (state_q == FLT_IDLE) && !irq)
    else $error("Enable pin low did not shut down");

  AST_TRIG_START: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_IDLE && trig_s) |=> state_q == FLT_FLASH)
    else $error("Trigger pin did not start a flash");

  AST_HW_TORCH: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && hardware_enable_pin_s && state_q == FLT_IDLE && cfg1_q[`FLT_CFG1_HWTORCH] && mfp_s
      && !flash_req) |=> state_q == FLT_TORCH)
    else $error("Pin torch request not honoured");

endmodule

// ===== test/flt_pa_model.sv
`timescale 1ns/10ps

// ****************************************
// Power amplifier controller model
// ****************************************
module flt_pa_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tx_req1,
  input wire logic tx_req2,
  input wire logic act_low,
  output logic multi_function_sync_pin,
  output logic pa_sync_input2
);
  // Pins pulled low in reset, change just after the edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      multi_function_sync_pin <= 1'b0;
      pa_sync_input2 <= 1'b0;
    end else begin
      multi_function_sync_pin <= tx_req1 ^ act_low;
      pa_sync_input2 <= tx_req2;
    end
  end
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
`include "flt_defines.svh"

module testbench;
  import flt_pkg::*;
  localparam int STEP = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  flt_bus_req_t bus = '0;
  flt_fault_t faults = '0;
  logic [7:0] rd_data, current_source_a, current_source_b, ta, tb, fa, fb, d;
  logic irq, multi_function_sync_pin, pa_sync_input2;
  logic hardware_enable_pin = 1'b1;
  logic flash_trigger_pin = 1'b0;
  logic tx_req1 = 1'b0;
  logic tx_req2 = 1'b0;
  logic act_low = 1'b0;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int on_cnt = 0;
  int seed = 7300;
  int i;

  flt_ctrl #(.STEP_CYCLES(STEP)) u_flt_ctrl (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(bus),
    .rd_data(rd_data), .hardware_enable_pin(hardware_enable_pin),
    .flash_trigger_pin(flash_trigger_pin), .multi_function_sync_pin(multi_function_sync_pin),
    .pa_sync_input2(pa_sync_input2), .faults(faults), .current_source_a(current_source_a),
    .current_source_b(current_source_b), .irq(irq));

  flt_pa_model u_flt_pa_model (.clk_sys(clk_sys), .rst(rst), .tx_req1(tx_req1),
    .tx_req2(tx_req2), .act_low(act_low), .multi_function_sync_pin(multi_function_sync_pin),
    .pa_sync_input2(pa_sync_input2));

  // ****************************************
  // Clock, watchdog, current monitor
  // ****************************************
  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  always @(negedge clk_sys) begin
    if (current_source_a !== 8'h00) on_cnt++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] nz();
    logic [7:0] r;
    r = 8'($random(seed));
    return r | 8'h01;
  endfunction

  function automatic logic [7:0] flash_len(input logic [4:0] n);
    return 8'((int'(n) + 1) * STEP);
  endfunction

  function automatic logic [7:0] flag_bit(input int k);
    logic [7:0] m [5];
    m = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02};
    return m[k];
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    chk(rd_data, exp);
    @(posedge clk_sys);
  endtask

  task automatic wait_cur(input logic [7:0] ea, input logic [7:0] eb, input int m);
    int k;
    for (k = 0; k < m; k++) begin
      @(negedge clk_sys);
      if (current_source_a === ea && current_source_b === eb) break;
    end
    chk(current_source_a, ea);
    chk(current_source_b, eb);
    @(posedge clk_sys);
  endtask

  task automatic irq_is(input logic b);
    @(negedge clk_sys);
    chk({7'h00, irq}, {7'h00, b});
    @(posedge clk_sys);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(`FLT_ADDR_CFG1, `FLT_RST_CFG1);
    rd(`FLT_ADDR_DUR, `FLT_RST_DUR);
    rd(`FLT_ADDR_STATUS, 8'h00);
    rd(`FLT_ADDR_CLEAR, 8'h00);
    rd(8'h3c, 8'h00);
    ta = nz();
    tb = nz();
    fa = nz();
    fb = nz();
    wr(`FLT_ADDR_TORCH_A, ta);
    wr(`FLT_ADDR_TORCH_B, tb);
    wr(`FLT_ADDR_FLASH_A, fa);
    wr(`FLT_ADDR_FLASH_B, fb);
    // Trigger flash, sync toggled mid-pulse
    wr(`FLT_ADDR_DUR, 8'h03);
    on_cnt = 0;
    flash_trigger_pin <= 1'b1;
    wait_cur(fa, fb, 12);
    tx_req1 <= 1'b1;
    wait_cur(ta, tb, 8);
    tx_req1 <= 1'b0;
    wait_cur(fa, fb, 8);
    wait_cur(8'h00, 8'h00, 24);
    chk(on_cnt[7:0], flash_len(5'h03));
    rd(`FLT_ADDR_STATUS, 8'h11);
    flash_trigger_pin <= 1'b0;
    wr(`FLT_ADDR_CLEAR, 8'hff);
    rd(`FLT_ADDR_STATUS, 8'h00);
    // Active low sync held through timeout
    act_low <= 1'b1;
    wr(`FLT_ADDR_CFG1, 8'h00);
    flash_trigger_pin <= 1'b1;
    wait_cur(fa, fb, 12);
    tx_req1 <= 1'b1;
    wait_cur(ta, tb, 8);
    wait_cur(8'h00, 8'h00, 24);
    tx_req1 <= 1'b0;
    flash_trigger_pin <= 1'b0;
    act_low <= 1'b0;
    // Second sync pin, random duration
    d = 8'h02 + 8'($random(seed) & 1);
    wr(`FLT_ADDR_CFG1, 8'h20);
    wr(`FLT_ADDR_DUR, d);
    wr(`FLT_ADDR_CLEAR, 8'hff);
    on_cnt = 0;
    flash_trigger_pin <= 1'b1;
    wait_cur(fa, fb, 12);
    tx_req2 <= 1'b1;
    wait_cur(ta, tb, 8);
    tx_req2 <= 1'b0;
    wait_cur(8'h00, 8'h00, 24);
    chk(on_cnt[7:0], flash_len(d[4:0]));
    rd(`FLT_ADDR_STATUS, 8'h11);
    flash_trigger_pin <= 1'b0;
    // Pin torch, trigger takes over
    wr(`FLT_ADDR_CFG1, 8'ha0);
    tx_req1 <= 1'b1;
    wait_cur(ta, tb, 8);
    flash_trigger_pin <= 1'b1;
    wait_cur(fa, fb, 8);
    wait_cur(8'h00, 8'h00, 24);
    rd(`FLT_ADDR_CFG1, 8'h20);
    tx_req1 <= 1'b0;
    flash_trigger_pin <= 1'b0;
    // Software torch, then software flash
    wr(`FLT_ADDR_ENABLE, 8'h1a);
    wait_cur(ta, tb, 8);
    wr(`FLT_ADDR_ENABLE, 8'h1b);
    wait_cur(fa, fb, 8);
    wait_cur(8'h00, 8'h00, 24);
    rd(`FLT_ADDR_ENABLE, 8'h18);
    // Enable pin drop in mid-flash
    wr(`FLT_ADDR_DUR, 8'h1f);
    flash_trigger_pin <= 1'b1;
    wait_cur(fa, fb, 12);
    hardware_enable_pin <= 1'b0;
    wait_cur(8'h00, 8'h00, 4);
    flash_trigger_pin <= 1'b0;
    hardware_enable_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`FLT_ADDR_DUR, `FLT_RST_DUR);
    rd(`FLT_ADDR_STATUS, 8'h00);
    // Fault flags and interrupt
    for (i = 0; i < 5; i++) begin
      faults <= flt_fault_t'(5'h01 << i);
      @(posedge clk_sys);
      faults <= '0;
      rd(`FLT_ADDR_STATUS, flag_bit(i));
      wr(`FLT_ADDR_CLEAR, 8'hff);
    end
    wr(`FLT_ADDR_IRQ_EN, 8'h02);
    faults <= flt_fault_t'(5'h10);
    @(posedge clk_sys);
    faults <= '0;
    irq_is(1'b1);
    wr(`FLT_ADDR_IRQ_EN, 8'h00);
    irq_is(1'b0);
    wr(`FLT_ADDR_IRQ_EN, 8'h02);
    irq_is(1'b1);
    wr(`FLT_ADDR_CLEAR, 8'h02);
    irq_is(1'b0);
    // Clock enable low freezes the flags
    ce <= 1'b0;
    faults <= flt_fault_t'(5'h10);
    @(posedge clk_sys);
    faults <= '0;
    ce <= 1'b1;
    irq_is(1'b0);
    close_out();
  end
endmodule
